//--- logic/tmc_params.svh
// Purpose: constants of the transceiver management block
// Assumes: 200 MHz aclk; byte index i of the map sits at AXI address 4*i
// Notes:   times keep their printed unit; cycle counts derive from them
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
// How it works
// - module is fully functional within 2000 ms of power-on or reset release
// - reset pin counts only when held low longer than 2 us
// - register bus answers within 2000 ms of supply becoming valid
// - within 2000 ms data-not-ready clears and the interrupt asserts
// - fully functional within 2000 ms after reset pin rises
// - low-power pin high drops to power level 1 within 100 us
// - low-power pin low returns to full operation within 300 ms
// - interrupt pin pulls low within 200 ms of a triggering condition
// - interrupt releases within 500 us after its flag is read clear
// - receive loss sets that lane's latched flag and interrupt in 100 ms
// - transmit fault sets that lane's latched flag and interrupt in 200 ms
// - other alarms and warnings set their flag and interrupt in 200 ms; transmit input loss (tx_in_lost) only squelches here, with no flag
// - mask bit set blocks, cleared restores, a flag's interrupt in 100 ms
// - rate-select changes take effect within 100 us
// - power-down bit enters level 1 in 100 ms, clearing restores in 300 ms
// - receive outputs squelch and unsquelch within 80 us of signal change
// - transmit output squelches and resumes within 400 ms of input change
// - lane transmit-disable turns output off in 100 ms, on in 400 ms
// - lane receive-disable turns output off and on within 100 ms
// - squelch-disable bit switches both squelches off and on in 100 ms
// - a directly addressed 128-byte lower region plus paged upper regions
// - upper pages 00, 02 and 03 exist; page 01 does not
// - reset completion and power-up post interrupt with data-not-ready low
// - page-select byte in the lower region picks the upper page
// - data-not-ready stays high until monitors valid, then stays low
`define TMC_CLK_NS       5
`define TMC_RST_MIN_US   2
`define TMC_RST_MIN_CYC  ((`TMC_RST_MIN_US * 1000 + `TMC_CLK_NS - 1) / `TMC_CLK_NS)
`define TMC_INIT_MS      2000
`define TMC_INIT_CYC     ((64'd1000000 * `TMC_INIT_MS) / `TMC_CLK_NS)
// byte indexes of the lower region, then the first index of the upper region
`define TMC_IDX_ID       8'h00
`define TMC_IDX_STATUS   8'h02
`define TMC_IDX_LOS      8'h03
`define TMC_IDX_FAULT    8'h04
`define TMC_IDX_TEMP     8'h06
`define TMC_IDX_VCC      8'h07
`define TMC_IDX_TXDIS    8'h56
`define TMC_IDX_RXDIS    8'h57
`define TMC_IDX_RATE     8'h58
`define TMC_IDX_PWR      8'h5D
`define TMC_IDX_SQDIS    8'h5E
`define TMC_IDX_M_LOS    8'h64
`define TMC_IDX_M_FLT    8'h65
`define TMC_IDX_M_TEMP   8'h67
`define TMC_IDX_M_VCC    8'h68
`define TMC_IDX_PAGE     8'h7F
`define TMC_UPPER_BASE   8'h80
// field positions and values
`define TMC_ID_VALUE     8'h0D
`define TMC_ST_DNR       0
`define TMC_ST_IRQ       1
`define TMC_ST_FLAT      2
`define TMC_PWR_OVR      0
`define TMC_PWR_SET      1
`define TMC_FLAG_LSB     4
`define TMC_PAGE_00      8'h00
`define TMC_PAGE_02      8'h02
`define TMC_PAGE_03      8'h03
`define TMC_RESP_OK      2'h0
`define TMC_RESP_DEC     2'h3
`define TMC_MASK_RST     4'h0
`define TMC_CTRL_RST     8'h00
`endif

//--- logic/tmc_pkg.sv
// Purpose: shared types of the transceiver management block
// Assumes: four lanes
// Notes:   constants live in tmc_params.svh
package tmc_pkg;
    typedef struct packed {
        logic [3:0] rx_los;
        logic [3:0] tx_fault;
        logic [3:0] tx_in_lost;
        logic [3:0] temp_alarm;
        logic [3:0] vcc_alarm;
    } tmc_cond_t;
    typedef struct packed {
        logic [3:0] tx_off;
        logic [3:0] rx_off;
        logic [7:0] rate_sel;
        logic       low_power;
    } tmc_lane_out_t;
    typedef struct packed {
        logic                awready, wready, wen, bvalid;
        logic [11:0]         awaddr;
        logic [7:0]          wdata;
        logic [1:0]          bresp;
        logic                arready, rvalid;
        logic [7:0]          rdata;
        logic [1:0]          rresp;
        logic [7:0]          page, tx_dis, rx_dis, rate, pwr;
        logic                sqdis;
        logic [3:0]          m_los, m_flt, m_temp, m_vcc;
        logic [3:0]          f_los, f_flt, f_temp, f_vcc;
        logic                dnr, init_flag, rst_hold, irq;
        tmc_lane_out_t       out;
    } tmc_state_t;
endpackage

//--- logic/tmc_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs come from outside the aclk domain
// Notes:   output moves only when stages two and three agree
`timescale 1ns/10ps
module tmc_sync #(
    parameter int unsigned       W    = 1,
    parameter logic [W-1:0]      INIT = '0
) (
    // clock and reset
    input  logic         aclk,
    input  logic         aresetn,
    // levels
    input  logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            out_q <= INIT;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            for (int i = 0; i < int'(W); i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s2_q[i];
                end
            end
        end
    end
    assign dout = out_q;
endmodule

//--- logic/tmc_wait.sv
// Purpose: run-length counter; done once run held LIMIT cycles
// Assumes: run drops to restart the count
// Notes:   done stays high while run stays high past the limit
`timescale 1ns/10ps
module tmc_wait #(
    parameter int unsigned  W     = 9,
    parameter logic [W-1:0] LIMIT = 1
) (
    // clock and reset
    input  logic aclk,
    input  logic aresetn,
    // control
    input  logic run,
    output logic done
);
    logic [W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = '0;
        end else if (cnt_q != LIMIT) begin
            cnt_d = cnt_q + 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    assign done = run && (cnt_q == LIMIT);
endmodule

//--- logic/tmc_mgmt.sv
// Purpose: management map, flags, interrupt and lane control of a module
// Assumes: AXI4-Lite, byte i of the map at address 4*i, data in bits 7:0
// Notes:   read data comes the cycle after the request is taken, the write response a cycle later than that
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`include "tmc_params.svh"
`timescale 1ns/10ps
module tmc_mgmt #(
    parameter int unsigned INIT_CYC = 32'(`TMC_INIT_CYC)
) (
    // clock and reset
    input  logic                   aclk,
    input  logic                   aresetn,
    // axi4-lite write address and data
    input  logic                   awvalid,
    output logic                   awready,
    input  logic [11:0]            awaddr,
    input  logic [2:0]             awprot,
    input  logic                   wvalid,
    output logic                   wready,
    input  logic [31:0]            wdata,
    input  logic [3:0]             wstrb,
    // axi4-lite write response
    output logic                   bvalid,
    input  logic                   bready,
    output logic [1:0]             bresp,
    // axi4-lite read
    input  logic                   arvalid,
    output logic                   arready,
    input  logic [11:0]            araddr,
    input  logic [2:0]             arprot,
    output logic                   rvalid,
    input  logic                   rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    // module pins
    input  logic                   reset_in_n,
    input  logic                   low_power_pin,
    input  logic                   irq_out_n_i,
    output logic                   irq_out_n_o,
    output logic                   irq_out_n_oe,
    // lane conditions and controls
    input  tmc_pkg::tmc_cond_t     cond_pins,
    output tmc_pkg::tmc_lane_out_t lane_ctl
);
    localparam int unsigned RW = 9;
    localparam int unsigned IW = 29;

    tmc_pkg::tmc_state_t s, n;
    tmc_pkg::tmc_cond_t  c;
    logic [7:0]          upper_mem [0:383];
    logic                rst_pin, lp_pin, irq_pin;
    logic                rst_long, init_done, lp;
    logic                mem_we;
    logic [8:0]          mem_waddr;
    logic [7:0]          rd_byte;
    logic [1:0]          rd_resp;
    logic [1:0]          wr_resp;

    // start at the idle pin levels so no false low-power or reset follows reset
    tmc_sync #(
        .W    (23),
        .INIT ({3'b110, 20'h00000})
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({reset_in_n, irq_out_n_i, low_power_pin, cond_pins}),
        .dout    ({rst_pin, irq_pin, lp_pin, c})
    );

    // reset pin must stay low for the minimum pulse before it counts
    tmc_wait #(
        .W     (RW),
        .LIMIT (RW'(`TMC_RST_MIN_CYC))
    ) u_rst_wait (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (!rst_pin),
        .done    (rst_long)
    );

    // init timer runs from power-on or reset-pin release
    tmc_wait #(
        .W     (IW),
        .LIMIT (IW'(INIT_CYC))
    ) u_init_wait (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (s.dnr && !s.rst_hold),
        .done    (init_done)
    );

    // page 01 is absent; anything outside the map decodes to an error
    function automatic logic addr_ok(input logic [11:0] a,
                                     input logic [7:0]  pg);
        logic ok;
        ok = (a[11:10] == 2'h0);
        if (a[9:2] >= `TMC_UPPER_BASE) begin
            ok = ok && (pg == `TMC_PAGE_00 || pg == `TMC_PAGE_02
                        || pg == `TMC_PAGE_03);
        end
        return ok;
    endfunction

    function automatic logic [8:0] mem_idx(input logic [7:0] idx,
                                           input logic [7:0] pg);
        logic [8:0] base;
        base = (pg == `TMC_PAGE_00) ? 9'h000 :
               (pg == `TMC_PAGE_02) ? 9'h080 : 9'h100;
        return base + {2'h0, idx[6:0]};
    endfunction

    logic [7:0] ridx;
    logic       r_ok;
    assign ridx = araddr[9:2];
    assign r_ok = addr_ok(araddr, s.page);

    always_comb begin
        rd_byte = 8'h00;
        unique case (ridx)
            `TMC_IDX_ID:     rd_byte = `TMC_ID_VALUE;
            `TMC_IDX_STATUS: begin
                rd_byte[`TMC_ST_FLAT] = 1'b1;
                rd_byte[`TMC_ST_IRQ]  = irq_pin;
                rd_byte[`TMC_ST_DNR]  = s.dnr;
            end
            `TMC_IDX_LOS:    rd_byte = {4'h0, s.f_los};
            `TMC_IDX_FAULT:  rd_byte = {4'h0, s.f_flt};
            `TMC_IDX_TEMP:   rd_byte = {s.f_temp, 4'h0};
            `TMC_IDX_VCC:    rd_byte = {s.f_vcc, 4'h0};
            `TMC_IDX_TXDIS:  rd_byte = s.tx_dis;
            `TMC_IDX_RXDIS:  rd_byte = s.rx_dis;
            `TMC_IDX_RATE:   rd_byte = s.rate;
            `TMC_IDX_PWR:    rd_byte = s.pwr;
            `TMC_IDX_SQDIS:  rd_byte = {7'h00, s.sqdis};
            `TMC_IDX_M_LOS:  rd_byte = {4'h0, s.m_los};
            `TMC_IDX_M_FLT:  rd_byte = {4'h0, s.m_flt};
            `TMC_IDX_M_TEMP: rd_byte = {s.m_temp, 4'h0};
            `TMC_IDX_M_VCC:  rd_byte = {s.m_vcc, 4'h0};
            `TMC_IDX_PAGE:   rd_byte = s.page;
            default: begin
                if (ridx >= `TMC_UPPER_BASE) begin
                    rd_byte = upper_mem[mem_idx(ridx, s.page)];
                end
            end
        endcase
        if (!r_ok) begin
            rd_byte = 8'h00;
        end
        rd_resp = r_ok ? `TMC_RESP_OK : `TMC_RESP_DEC;
    end

    logic [7:0] widx;
    logic       w_go;
    assign widx      = s.awaddr[9:2];
    assign w_go      = !s.awready && !s.wready && !s.bvalid;
    assign wr_resp   = addr_ok(s.awaddr, s.page) ? `TMC_RESP_OK
                                                 : `TMC_RESP_DEC;
    assign mem_we    = w_go && s.wen && (wr_resp == `TMC_RESP_OK)
                       && (widx >= `TMC_UPPER_BASE);
    assign mem_waddr = mem_idx(widx, s.page);

    // upper pages are plain storage; no reset needed
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            upper_mem[mem_waddr] <= s.wdata;
        end
    end

    always_comb begin
        n = s;
        // write channel: address and data taken in either order
        if (awvalid && s.awready) begin
            n.awaddr  = awaddr;
            n.awready = 1'b0;
        end
        if (wvalid && s.wready) begin
            n.wdata  = wdata[7:0];
            n.wen    = wstrb[0];
            n.wready = 1'b0;
        end
        // register effects start as the response is raised
        if (w_go) begin
            n.bvalid = 1'b1;
            n.bresp  = wr_resp;
            if (s.wen && wr_resp == `TMC_RESP_OK) begin
                unique case (widx)
                    `TMC_IDX_TXDIS:  n.tx_dis = s.wdata;
                    `TMC_IDX_RXDIS:  n.rx_dis = s.wdata;
                    `TMC_IDX_RATE:   n.rate   = s.wdata;
                    `TMC_IDX_PWR:    n.pwr    = s.wdata;
                    `TMC_IDX_SQDIS:  n.sqdis  = s.wdata[0];
                    `TMC_IDX_M_LOS:  n.m_los  = s.wdata[3:0];
                    `TMC_IDX_M_FLT:  n.m_flt  = s.wdata[3:0];
                    `TMC_IDX_M_TEMP: n.m_temp = s.wdata[7:4];
                    `TMC_IDX_M_VCC:  n.m_vcc  = s.wdata[7:4];
                    `TMC_IDX_PAGE:   n.page   = s.wdata;
                    default: ;
                endcase
            end
        end
        if (s.bvalid && bready) begin
            n.bvalid  = 1'b0;
            n.awready = 1'b1;
            n.wready  = 1'b1;
        end
        // read channel; latched flags clear when their byte is read
        if (arvalid && s.arready) begin
            n.arready = 1'b0;
            n.rvalid  = 1'b1;
            n.rdata   = rd_byte;
            n.rresp   = rd_resp;
            if (r_ok) begin
                unique case (ridx)
                    `TMC_IDX_STATUS: n.init_flag = 1'b0;
                    `TMC_IDX_LOS:    n.f_los     = 4'h0;
                    `TMC_IDX_FAULT:  n.f_flt     = 4'h0;
                    `TMC_IDX_TEMP:   n.f_temp    = 4'h0;
                    `TMC_IDX_VCC:    n.f_vcc     = 4'h0;
                    default: ;
                endcase
            end
        end
        if (s.rvalid && rready) begin
            n.rvalid  = 1'b0;
            n.arready = 1'b1;
        end
        // a condition present in the clearing cycle sets the flag again
        n.f_los  = n.f_los  | c.rx_los;
        n.f_flt  = n.f_flt  | c.tx_fault;
        n.f_temp = n.f_temp | c.temp_alarm;
        n.f_vcc  = n.f_vcc  | c.vcc_alarm;
        // module reset from the pin, then a fresh init
        if (rst_long) begin
            n.rst_hold = 1'b1;
        end else if (rst_pin) begin
            n.rst_hold = 1'b0;
        end
        if (init_done) begin
            n.dnr       = 1'b0;
            n.init_flag = 1'b1;
        end
        if (s.rst_hold) begin
            n.dnr       = 1'b1;
            n.init_flag = 1'b0;
            n.tx_dis    = `TMC_CTRL_RST;
            n.rx_dis    = `TMC_CTRL_RST;
            n.rate      = `TMC_CTRL_RST;
            n.pwr       = `TMC_CTRL_RST;
            n.page      = `TMC_CTRL_RST;
            n.sqdis     = 1'b0;
            n.m_los     = `TMC_MASK_RST;
            n.m_flt     = `TMC_MASK_RST;
            n.m_temp    = `TMC_MASK_RST;
            n.m_vcc     = `TMC_MASK_RST;
            n.f_los     = 4'h0;
            n.f_flt     = 4'h0;
            n.f_temp    = 4'h0;
            n.f_vcc     = 4'h0;
        end
        // unmasked flags or completed init pull the interrupt low
        n.irq = s.init_flag
              | (|(s.f_los  & ~s.m_los))
              | (|(s.f_flt  & ~s.m_flt))
              | (|(s.f_temp & ~s.m_temp))
              | (|(s.f_vcc  & ~s.m_vcc));
        // lane controls follow their bits on the next edge
        n.out.low_power = lp;
        n.out.rate_sel  = s.rate;
        n.out.tx_off    = s.tx_dis[3:0]
                        | (c.tx_in_lost & {4{!s.sqdis}})
                        | {4{lp}};
        n.out.rx_off    = s.rx_dis[3:0]
                        | (c.rx_los & {4{!s.sqdis}});
    end

    // power override selects the software bit over the pin
    assign lp = s.pwr[`TMC_PWR_OVR] ? s.pwr[`TMC_PWR_SET] : lp_pin;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s          <= '0;
            s.awready  <= 1'b1;
            s.wready   <= 1'b1;
            s.arready  <= 1'b1;
            s.dnr      <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign awready      = s.awready;
    assign wready       = s.wready;
    assign bvalid       = s.bvalid;
    assign bresp        = s.bresp;
    assign arready      = s.arready;
    assign rvalid       = s.rvalid;
    assign rdata        = {24'h000000, s.rdata};
    assign rresp        = s.rresp;
    assign irq_out_n_o  = 1'b0;
    assign irq_out_n_oe = s.irq;
    assign lane_ctl     = s.out;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_init_fall;
        s.dnr ##1 !s.dnr;
    endsequence
    property p_init_irq;
        s_init_fall |=> irq_out_n_oe;
    endproperty
    a_init_irq: assert property (p_init_irq)
        else $error("init done without interrupt");

    property p_dnr_low;
        !s.dnr && !s.rst_hold |=> !s.dnr;
    endproperty
    a_dnr_low: assert property (p_dnr_low)
        else $error("data not ready rose again");

    property p_lp_enter;
        lp_pin && !s.pwr[`TMC_PWR_OVR] && !s.rst_hold
            |=> ##[0:1] lane_ctl.low_power;
    endproperty
    a_lp_enter: assert property (p_lp_enter)
        else $error("low power not entered");

    property p_los_flag;
        c.rx_los[0] && !s.rst_hold |=> s.f_los[0];
    endproperty
    a_los_flag: assert property (p_los_flag)
        else $error("loss flag not latched");

    property p_flt_irq;
        c.tx_fault[1] && !s.m_flt[1] && !s.rst_hold
            ##1 !s.rst_hold |=> irq_out_n_oe;
    endproperty
    a_flt_irq: assert property (p_flt_irq)
        else $error("fault did not raise interrupt");

    property p_mask_all;
        (&(s.m_los | ~s.f_los)) && (&(s.m_flt | ~s.f_flt))
            && (&(s.m_temp | ~s.f_temp)) && (&(s.m_vcc | ~s.f_vcc))
            && !s.init_flag |=> !irq_out_n_oe;
    endproperty
    a_mask_all: assert property (p_mask_all)
        else $error("masked flag raised interrupt");

    property p_txdis;
        s.tx_dis[0] |=> lane_ctl.tx_off[0];
    endproperty
    a_txdis: assert property (p_txdis)
        else $error("tx disable ignored");

    property p_rx_sq;
        (c.rx_los[0] && !s.sqdis) [*2] |=> lane_ctl.rx_off[0];
    endproperty
    a_rx_sq: assert property (p_rx_sq)
        else $error("rx not squelched");

    property p_rst_min;
        $rose(rst_long) |-> $past(!rst_pin, 2);
    endproperty
    a_rst_min: assert property (p_rst_min)
        else $error("short reset pulse accepted");
endmodule

//--- dv/tmc_host_pins.sv
// Purpose: host side pins: pulled-up interrupt wire and reset pulser
// Assumes: interrupt pin is open drain with a pull-up on the host
// Notes:   rst_len loads a low pulse of that many aclk cycles
`timescale 1ns/10ps
module tmc_host_pins (
    // clock
    input  wire logic        aclk,
    // interrupt wire
    input  wire logic        irq_oe,
    input  wire logic        irq_o,
    output wire logic        irq_wire,
    // reset pulse
    input  wire logic [15:0] rst_len,
    output wire logic        reset_in_n
);
    logic [15:0] cnt_q = 16'h0000;
    // a released wire shows the pull-up level, never the last driven one
    assign irq_wire   = irq_oe ? irq_o : 1'b1;
    assign reset_in_n = (cnt_q == 16'h0000);
    always_ff @(posedge aclk) begin
        if (rst_len != 16'h0000) cnt_q <= rst_len;
        else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
    end
endmodule

//--- dv/transceiver_mgmt_control_timing_tb_top.sv
// Purpose: register-level regression of the management block
// Assumes: INIT_CYC shortened to 50 cycles
// Notes:   every wait is bounded; a hang counts as a mismatch
`include "tmc_params.svh"
`timescale 1ns/10ps
module transceiver_mgmt_control_timing_tb_top;
    logic               aclk = 1'b0, aresetn = 1'b0, lp = 1'b0;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0;
    logic [11:0]        awaddr = 12'h000, araddr = 12'h000;
    logic [31:0]        wdata = 32'h0, rdata;
    logic [15:0]        rst_len = 16'h0000;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [1:0]         bresp, rresp;
    logic               irq_o, irq_oe, irq_wire, rst_n;
    tmc_pkg::tmc_cond_t     cond = '0;
    tmc_pkg::tmc_lane_out_t lane;
    int                 fails = 0, samples_checked = 0;
    int                 pos[4] = '{17, 13, 5, 1};
    logic [7:0]         fi[4] = '{8'h03, 8'h04, 8'h06, 8'h07};
    logic [7:0]         mi[4] = '{8'h64, 8'h65, 8'h67, 8'h68};
    logic [7:0]         fv[4] = '{8'h02, 8'h02, 8'h20, 8'h20};
    tmc_mgmt #(.INIT_CYC(50)) i_tmc_mgmt (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .reset_in_n(rst_n), .low_power_pin(lp),
        .irq_out_n_i(irq_wire), .irq_out_n_o(irq_o),
        .irq_out_n_oe(irq_oe), .cond_pins(cond), .lane_ctl(lane));
    tmc_host_pins i_tmc_host_pins (.aclk(aclk), .irq_oe(irq_oe),
        .irq_o(irq_o), .irq_wire(irq_wire), .rst_len(rst_len),
        .reset_in_n(rst_n));
    initial forever #2.5 aclk = ~aclk;
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic hung();
        fails++;
        $display("ERROR %0t: wait ran out", $time);
        end_of_test();
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // requests change only after an edge and drop at the edge they are taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        logic aw, w, b, ra, rw, rb;
        logic [1:0] rs;
        int n;
        aw = 1'b1; w = 1'b1; b = 1'b1; n = 0;
        awaddr <= a; wdata <= {24'h0, d}; bready <= 1'b1;
        awvalid <= 1'b1; wvalid <= 1'b1;
        while (b) begin
            @(negedge aclk);
            ra = awready; rw = wready; rb = bvalid; rs = bresp;
            @(posedge aclk);
            if (aw && ra) begin aw = 1'b0; awvalid <= 1'b0; end
            if (w && rw) begin w = 1'b0; wvalid <= 1'b0; end
            if (rb) b = 1'b0;
            if (++n > 100) hung();
        end
        chk(32'(rs), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] ed,
                      input logic [1:0] er);
        logic ar, rv, ra;
        logic [31:0] dv;
        logic [1:0] rs;
        int n;
        tk(5); // synchronised pins and conditions settle before the read
        ar = 1'b1; rv = 1'b0; n = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!rv) begin
            @(negedge aclk);
            ra = arready; rv = rvalid; dv = rdata; rs = rresp;
            @(posedge aclk);
            if (ar && ra) begin ar = 1'b0; arvalid <= 1'b0; end
            if (rv) rready <= 1'b0;
            if (++n > 100) hung();
        end
        chk(dv, {24'h0, ed});
        chk(32'(rs), 32'(er));
    endtask
    task automatic wirq(input logic lvl);
        int n;
        n = 0;
        while (irq_wire !== lvl) begin
            @(posedge aclk);
            if (++n > 300) hung();
        end
        chk(32'(irq_wire), 32'(lvl));
    endtask
    initial begin
        tk(12);
        aresetn <= 1'b1;
        rd(ad(`TMC_IDX_STATUS), 8'h07, `TMC_RESP_OK);
        wirq(1'b0);
        rd(ad(`TMC_IDX_STATUS), 8'h04, `TMC_RESP_OK);
        wirq(1'b1);
        rd(ad(`TMC_IDX_STATUS), 8'h06, `TMC_RESP_OK);
        $display("test power-up done");
        wr(ad(`TMC_IDX_PAGE), `TMC_PAGE_02, `TMC_RESP_OK);
        wr(ad(`TMC_UPPER_BASE), 8'hA5, `TMC_RESP_OK);
        wr(ad(`TMC_IDX_PAGE), `TMC_PAGE_03, `TMC_RESP_OK);
        wr(ad(`TMC_UPPER_BASE), 8'h3C, `TMC_RESP_OK);
        rd(ad(`TMC_UPPER_BASE), 8'h3C, `TMC_RESP_OK);
        wr(ad(`TMC_IDX_PAGE), `TMC_PAGE_02, `TMC_RESP_OK);
        rd(ad(`TMC_UPPER_BASE), 8'hA5, `TMC_RESP_OK);
        wr(ad(`TMC_IDX_PAGE), 8'h01, `TMC_RESP_OK);
        wr(ad(`TMC_UPPER_BASE), 8'h11, `TMC_RESP_DEC);
        rd(ad(`TMC_UPPER_BASE), 8'h00, `TMC_RESP_DEC);
        rd(ad(`TMC_IDX_ID), `TMC_ID_VALUE, `TMC_RESP_OK);
        wr(12'hC00, 8'h00, `TMC_RESP_DEC);
        wr(ad(`TMC_IDX_PAGE), `TMC_PAGE_00, `TMC_RESP_OK);
        wr(ad(`TMC_UPPER_BASE), 8'h77, `TMC_RESP_OK);
        rd(ad(`TMC_UPPER_BASE), 8'h77, `TMC_RESP_OK);
        $display("test pages done");
        for (int k = 0; k < 4; k++) begin
            cond <= tmc_pkg::tmc_cond_t'(20'h1 << pos[k]);
            wirq(1'b0);
            cond <= '0;
            rd(ad(fi[k]), fv[k], `TMC_RESP_OK);
            wirq(1'b1);
            wr(ad(mi[k]), fv[k], `TMC_RESP_OK);
            cond <= tmc_pkg::tmc_cond_t'(20'h1 << pos[k]);
            tk(10);
            chk(32'(irq_wire), 32'h1);
            wr(ad(mi[k]), 8'h00, `TMC_RESP_OK);
            wirq(1'b0);
            cond <= '0;
            rd(ad(fi[k]), fv[k], `TMC_RESP_OK);
            wirq(1'b1);
        end
        $display("test flags done");
        wr(ad(`TMC_IDX_TXDIS), 8'h05, `TMC_RESP_OK);
        wr(ad(`TMC_IDX_RXDIS), 8'h0A, `TMC_RESP_OK);
        wr(ad(`TMC_IDX_RATE), 8'h3C, `TMC_RESP_OK);
        tk(2);
        chk(32'(lane), 32'({4'h5, 4'hA, 8'h3C, 1'b0}));
        cond <= tmc_pkg::tmc_cond_t'(20'h10800);
        tk(10);
        chk(32'(lane), 32'({4'hD, 4'hB, 8'h3C, 1'b0}));
        wr(ad(`TMC_IDX_SQDIS), 8'h01, `TMC_RESP_OK);
        tk(2);
        chk(32'(lane), 32'({4'h5, 4'hA, 8'h3C, 1'b0}));
        wr(ad(`TMC_IDX_SQDIS), 8'h00, `TMC_RESP_OK);
        cond <= '0;
        lp <= 1'b1;
        tk(10);
        chk(32'(lane), 32'({4'hF, 4'hA, 8'h3C, 1'b1}));
        lp <= 1'b0;
        tk(10);
        chk(32'(lane), 32'({4'h5, 4'hA, 8'h3C, 1'b0}));
        wr(ad(`TMC_IDX_PWR), 8'h03, `TMC_RESP_OK);
        tk(2);
        chk(32'(lane), 32'({4'hF, 4'hA, 8'h3C, 1'b1}));
        wr(ad(`TMC_IDX_PWR), 8'h01, `TMC_RESP_OK);
        tk(2);
        chk(32'(lane), 32'({4'h5, 4'hA, 8'h3C, 1'b0}));
        rd(ad(`TMC_IDX_LOS), 8'h01, `TMC_RESP_OK);
        wirq(1'b1);
        $display("test lanes done");
        // 100 cycles is below the 400-sample reset filter, 450 above it
        rst_len <= 16'd100;
        tk(1);
        rst_len <= 16'h0000;
        tk(120);
        rd(ad(`TMC_IDX_TXDIS), 8'h05, `TMC_RESP_OK);
        rst_len <= 16'd450;
        tk(1);
        rst_len <= 16'h0000;
        tk(460);
        rd(ad(`TMC_IDX_TXDIS), 8'h00, `TMC_RESP_OK);
        rd(ad(`TMC_IDX_STATUS), 8'h07, `TMC_RESP_OK);
        wirq(1'b0);
        rd(ad(`TMC_IDX_STATUS), 8'h04, `TMC_RESP_OK);
        $display("test pin reset done");
        end_of_test();
    end
endmodule
